// ==== verilog/isb_ctrl.sv ====
// Burst read controller for a two-bank interleaved instruction SRAM.
`include "isb_cfg.svh"

module isb_ctrl
    import isb_pkg::*;
#(
    parameter int ADDR_W = `ISB_ADDR_W,
    parameter int SEL_LSB = `ISB_SEL_LSB,
    parameter logic [ADDR_W-SEL_LSB-1:0] SEL_BASE = `ISB_SEL_BASE
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic instr_request_in,
    input wire logic [ADDR_W-1:0] instr_address_in,
    input wire logic instr_burst_request_in,
    output logic instr_memory_select_out,
    output logic counter_load_strobe_out,
    output logic instr_burst_ack_out,
    output logic burst_request_delayed_out,
    output logic burst_ack_delayed_out,
    output logic counter_advance_out,
    output logic instr_ready_resp_out,
    output logic even_bank_output_en_out,
    output logic odd_bank_output_en_out,
    output logic [`ISB_BANK_ADDR_W-1:0] even_bank_addr_out,
    output logic [`ISB_BANK_ADDR_W-1:0] odd_bank_addr_out,
    output logic data_output_en_out,
    output logic write_en_out
);

    isb_state_t state_q;
    isb_state_t state_d;
    logic [`ISB_CNT_W-1:0] even_cnt_q;
    logic [`ISB_CNT_W-1:0] odd_cnt_q;
    logic [`ISB_CNT_W-1:0] even_cnt_d;
    logic [`ISB_CNT_W-1:0] odd_cnt_d;
    logic [`ISB_CNT_W-1:0] load_addr;
    logic burst_req_d_q;
    logic burst_ack_d_q;
    logic first_pend_q;
    logic first_pend_d;
    logic word_odd_q;
    logic word_odd_d;

    wire logic select_hit;
    wire logic load_now;
    wire logic in_access;
    wire logic advance;
    wire logic ready;
    wire logic burst_done;

    // Selection decode, shared by the strobe logic and the checks below.
    function automatic logic hits_block(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SEL_LSB] == SEL_BASE;
    endfunction

    // Block selection is a plain compare of the upper address bits.
    assign select_hit = hits_block(instr_address_in);
    assign instr_memory_select_out = instr_request_in & select_hit;
    // A selected request loads the counters at the coming edge.
    assign load_now = instr_request_in & select_hit;
    assign counter_load_strobe_out = load_now;

    assign in_access = state_q == ISB_IACCESS;
    assign instr_burst_ack_out = in_access;
    assign burst_request_delayed_out = burst_req_d_q;
    assign burst_ack_delayed_out = burst_ack_d_q;

    assign advance = burst_req_d_q & in_access;
    assign counter_advance_out = advance;

    // The bus carries a word one cycle after the ack, and only while the delayed burst
    // request stands; a lone first word is still answered when no burst was asked for.
    assign ready = in_access & burst_ack_d_q & (burst_req_d_q | first_pend_q);
    assign instr_ready_resp_out = ready;

    // Which bank owns the word on the bus alternates with each delivered word.
    assign even_bank_output_en_out = ready & ~word_odd_q;
    assign odd_bank_output_en_out = ready & word_odd_q;

    // Only the upper counter bits reach the memory; the low bit only steers counting.
    assign even_bank_addr_out = even_cnt_q[`ISB_CNT_W-1:1];
    assign odd_bank_addr_out = odd_cnt_q[`ISB_CNT_W-1:1];

    // This block never serves data-side accesses or writes.
    assign data_output_en_out = 1'b0;
    assign write_en_out = 1'b0;

    // A single read ends after its word; a burst past its first word never ends here, as ready then needs the delayed request.
    assign burst_done = ready & ~instr_burst_request_in & ~burst_req_d_q;

    // The counter works on word addresses, so the byte offset bits are left out.
    assign load_addr = instr_address_in[`ISB_WORD_LSB+`ISB_CNT_W-1:`ISB_WORD_LSB];

    // An odd start rounds the even counter up so that bank fetches the following even word.
    always_comb begin
        even_cnt_d = even_cnt_q;
        odd_cnt_d = odd_cnt_q;
        if (load_now) begin
            even_cnt_d = load_addr + {{(`ISB_CNT_W-1){1'b0}}, load_addr[0]};
            odd_cnt_d = load_addr;
        end else if (advance) begin
            even_cnt_d = even_cnt_q + 8'h01;
            odd_cnt_d = odd_cnt_q + 8'h01;
        end
    end

    always_comb begin
        first_pend_d = first_pend_q;
        word_odd_d = word_odd_q;
        if (load_now) begin
            first_pend_d = 1'b1;
            word_odd_d = load_addr[0];
        end else if (ready) begin
            first_pend_d = 1'b0;
            word_odd_d = ~word_odd_q;
        end
    end

    always_comb begin
        case (state_q)
            ISB_IDLE: begin
                state_d = load_now ? ISB_IACCESS : ISB_IDLE;
            end
            ISB_IACCESS: begin
                if (load_now) begin
                    state_d = ISB_IACCESS;
                end else if (instr_request_in | burst_done) begin
                    state_d = ISB_IDLE;
                end else begin
                    state_d = ISB_IACCESS;
                end
            end
            default: begin
                state_d = ISB_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ISB_IDLE;
            burst_req_d_q <= 1'b0;
            burst_ack_d_q <= 1'b0;
        end else begin
            state_q <= state_d;
            burst_req_d_q <= instr_burst_request_in;
            // The ack copy restarts on a reload so the first word keeps its latency.
            burst_ack_d_q <= in_access & ~load_now;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            even_cnt_q <= 8'h00;
            odd_cnt_q <= 8'h00;
            first_pend_q <= 1'b0;
            word_odd_q <= 1'b0;
        end else begin
            even_cnt_q <= even_cnt_d;
            odd_cnt_q <= odd_cnt_d;
            first_pend_q <= first_pend_d;
            word_odd_q <= word_odd_d;
        end
    end

    chk_load_capture: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now |=> instr_burst_ack_out && odd_cnt_q == $past(load_addr))
        else $error("Counters did not capture the address after the load strobe.");

    chk_first_address: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now && !load_addr[0] |=> even_bank_addr_out == $past(load_addr[7:1]))
        else $error("First word address missing in the second access cycle.");

    chk_first_word: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now ##1 !instr_request_in |=> instr_ready_resp_out)
        else $error("First word not ready in the third cycle.");

    chk_delayed_advance: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        instr_burst_request_in ##1 instr_burst_ack_out |-> counter_advance_out)
        else $error("Delayed burst request with ack did not advance the counter.");

    chk_suspend_hold: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !instr_burst_request_in && !instr_request_in ##1 !instr_request_in |->
            !counter_advance_out ##1 ($stable(even_cnt_q) && $stable(odd_cnt_q)))
        else $error("Counters moved during a burst suspension.");

    chk_count_step: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        counter_advance_out && !load_now |=>
            even_cnt_q == $past(even_cnt_q) + 8'h01 && odd_cnt_q == $past(odd_cnt_q) + 8'h01)
        else $error("Counter did not increment after an advance.");

    chk_half_rate: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (counter_advance_out && !load_now) ##1 (counter_advance_out && !load_now) |=>
            odd_bank_addr_out == $past(odd_bank_addr_out, 2) + 7'h01)
        else $error("Bank address did not step once per two advances.");

    chk_ready_drop: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !burst_req_d_q && !first_pend_q |-> !instr_ready_resp_out)
        else $error("Ready stayed high with the delayed burst request inactive.");

    chk_resume: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        burst_ack_d_q && in_access && !burst_req_d_q && !load_now ##1 burst_req_d_q && in_access
            |->
            instr_ready_resp_out && counter_advance_out)
        else $error("Ready or advance missing when the burst resumed.");

    chk_oe_alternate: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        even_bank_output_en_out ##1 (instr_ready_resp_out && !$past(load_now)) |->
            odd_bank_output_en_out && !even_bank_output_en_out)
        else $error("Bank output enables did not alternate.");

    chk_oe_first: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now && load_addr[0] ##1 !instr_request_in |=>
            odd_bank_output_en_out && !even_bank_output_en_out)
        else $error("Odd start did not enable the odd bank first.");

    chk_no_data_side: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        instr_burst_ack_out |-> !data_output_en_out && !write_en_out)
        else $error("Data-side or write enable active during an instruction read.");

    chk_burst_copy: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> burst_request_delayed_out == $past(instr_burst_request_in))
        else $error("Delayed burst request is not last cycle's request.");

    chk_ack_restart: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now |=> !burst_ack_delayed_out)
        else $error("Ack copy did not restart on a load.");

    chk_ack_delay: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        instr_burst_ack_out && !load_now |=> burst_ack_delayed_out)
        else $error("Ack copy did not follow the ack.");

    chk_select_load: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        instr_request_in && hits_block(instr_address_in) |->
            counter_load_strobe_out && instr_memory_select_out)
        else $error("Selected request did not raise the load strobe.");

    chk_refused_pass: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !(instr_request_in && hits_block(instr_address_in)) |->
            !counter_load_strobe_out && !instr_memory_select_out)
        else $error("Load strobe raised without a selected request.");

    chk_leave_access: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        in_access && instr_request_in && !load_now |=> !instr_burst_ack_out)
        else $error("Access kept after a request for another block.");

    chk_single_end: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        instr_ready_resp_out && !instr_burst_request_in && !burst_req_d_q && !instr_request_in
            |=> !instr_burst_ack_out)
        else $error("Access did not end after the last word.");

    chk_oe_match: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (even_bank_output_en_out || odd_bank_output_en_out) == instr_ready_resp_out &&
            !(even_bank_output_en_out && odd_bank_output_en_out))
        else $error("Bank output enables do not match the ready response.");

    chk_idle_quiet: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !instr_burst_ack_out |-> !counter_advance_out && !instr_ready_resp_out)
        else $error("Advance or ready active outside an access.");

    chk_hold_value: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !counter_advance_out && !load_now |=> $stable(even_cnt_q) && $stable(odd_cnt_q))
        else $error("Counters moved without an advance or a load.");

    chk_odd_round: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        load_now && load_addr[0] |=> even_cnt_q == $past(load_addr) + 8'h01)
        else $error("Odd start did not point the even bank at the next word.");

endmodule // isb_ctrl

// ==== verilog/isb_cfg.svh ====
// Constants for the interleaved instruction SRAM burst read controller.
`ifndef ISB_CFG_SVH
`define ISB_CFG_SVH

// Width of each bank address counter; the low bit only steers counting.
`define ISB_CNT_W 8
// Lowest address bit that names a word; the counter is loaded from here upward.
`define ISB_WORD_LSB 2
// Memory address lines driven by each bank counter (its upper bits).
`define ISB_BANK_ADDR_W 7
// Instruction address width seen from the processor.
`define ISB_ADDR_W 32
// Lowest address bit that takes part in block selection.
`define ISB_SEL_LSB 10
// Default base of this memory block, compared on the select bits.
`define ISB_SEL_BASE 22'h000000
// Cycles from the load strobe to the first ready response.
`define ISB_LOAD_TO_READY 2

`endif

// ==== verilog/isb_pkg.sv ====
// Types for the interleaved instruction SRAM burst read controller.
package isb_pkg;

    typedef enum logic [0:0] {
        ISB_IDLE,
        ISB_IACCESS
    } isb_state_t;

endpackage

// ==== bench/isb_proc_model.sv ====
// Instruction bus master model that issues fetches and logs the block's answers.
module isb_proc_model (
    input wire logic ref_clk_in,
    output logic instr_request_out,
    output logic [31:0] instr_address_out,
    output logic instr_burst_request_out,
    input wire logic load_in,
    input wire logic ack_in,
    input wire logic adv_in,
    input wire logic ready_in,
    input wire logic even_oe_in,
    input wire logic odd_oe_in,
    input wire logic side_en_in,
    input wire logic [6:0] even_addr_in,
    input wire logic [6:0] odd_addr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lg [0:15];
    logic [6:0] ea [0:15];
    logic [6:0] oa [0:15];
    logic ld1;

    initial begin
        instr_request_out = 1'b0;
        instr_address_out = 32'hffff_ffff;
        instr_burst_request_out = 1'b0;
    end

    // Log index k holds cycle k; samples are taken just before the falling-edge drive.
    task automatic fetch(input logic [31:0] addr, input logic [15:0] pat, input int n);
        int k;
        @(negedge ref_clk_in);
        instr_request_out = 1'b1;
        instr_address_out = addr;
        instr_burst_request_out = pat[0];
        #1 ld1 = load_in;
        for (k = 1; k <= n; k++) begin
            @(negedge ref_clk_in);
            lg[k+1] = {side_en_in, odd_oe_in, even_oe_in, ready_in, adv_in, ack_in};
            ea[k+1] = even_addr_in;
            oa[k+1] = odd_addr_in;
            instr_request_out = 1'b0;
            // A released address bus is shown inverted so stale values cannot match.
            instr_address_out = ~addr;
            instr_burst_request_out = pat[k];
        end
    endtask
endmodule // isb_proc_model

// ==== bench/tb_interleaved_sram_instr_burst_read.sv ====
// Self-checking bench for the interleaved instruction SRAM burst read controller.
module tb_interleaved_sram_instr_burst_read;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req, breq, ld, ack, adv, rdy, eoe, ooe, doe, we;
    logic [31:0] addr;
    logic [6:0] ea;
    logic [6:0] oa;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2 ref_clk_in = ~ref_clk_in;

    isb_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_request_in(req),
        .instr_address_in(addr), .instr_burst_request_in(breq),
        .instr_memory_select_out(), .counter_load_strobe_out(ld), .instr_burst_ack_out(ack),
        .burst_request_delayed_out(), .burst_ack_delayed_out(), .counter_advance_out(adv),
        .instr_ready_resp_out(rdy), .even_bank_output_en_out(eoe),
        .odd_bank_output_en_out(ooe), .even_bank_addr_out(ea), .odd_bank_addr_out(oa),
        .data_output_en_out(doe), .write_en_out(we));

    isb_proc_model i_proc (.ref_clk_in(ref_clk_in), .instr_request_out(req),
        .instr_address_out(addr), .instr_burst_request_out(breq), .load_in(ld),
        .ack_in(ack), .adv_in(adv), .ready_in(rdy), .even_oe_in(eoe), .odd_oe_in(ooe),
        .side_en_in(doe | we), .even_addr_in(ea), .odd_addr_in(oa));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Ceiling is far above the roughly 35 cycles the scenarios need.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end

    // Burst whose burst request follows pat cycle by cycle; each word expected from the pattern.
    task automatic run_burst(input logic [31:0] a, input logic [15:0] pat, input int n);
        int c, w;
        logic r, e;
        i_proc.fetch(a, pat, n);
        check(i_proc.ld1, 1);
        w = 0;
        for (c = 2; c <= n + 1; c++) begin
            r = (c == 3) || (c > 3 && pat[c-2]);
            e = r && !(a[2] ^ w[0]);
            check(i_proc.lg[c], {1'b0, r & ~e, e, r, pat[c-2], 1'b1});
            w += r;
        end
    endtask

    task automatic t_burst_even();
        run_burst(32'h0000_0000, 16'h00af, 9);
        check(i_proc.ea[7], i_proc.ea[6]);
        check(i_proc.ea[8], 7'h02);
        check(i_proc.oa[7], i_proc.oa[6]);
        check(i_proc.oa[8], 7'h02);
    endtask

    // Issued while the previous burst is still open, so it also covers a reload.
    task automatic t_burst_odd();
        run_burst(32'h0000_0004, 16'h00af, 9);
    endtask

    task automatic t_refused();
        i_proc.fetch(32'h0000_0400, 16'hffff, 3);
        check(i_proc.ld1, 0);
        check(i_proc.lg[3], 6'h00);
        check(i_proc.lg[4], 6'h00);
    endtask

    task automatic t_single();
        i_proc.fetch(32'h0000_0000, 16'h0000, 4);
        check(i_proc.lg[2], 6'h01);
        check(i_proc.lg[3], 6'h0d);
        check(i_proc.lg[4], 6'h00);
        check(i_proc.lg[5], 6'h00);
    endtask

    initial begin
        repeat (5) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        t_burst_even();
        t_burst_odd();
        t_refused();
        t_single();
        close_out();
    end
endmodule // tb_interleaved_sram_instr_burst_read
